// *** design/fspg_guard.sv ***
// Self-programming access guard: lock checks, region halt and busy flag.
`timescale 1ns/10ps
module fspg_guard #(
    parameter logic [fspg_pkg::ADDR_W-1:0] HALT_START = fspg_pkg::HALT_START_DEF, // [R22]
    parameter logic [fspg_pkg::ADDR_W-1:0] BOOT_START = fspg_pkg::BOOT_START_DEF  // [R22]
) (
    // Clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    // Core requests
    input  wire fspg_pkg::fspg_store_req_t store_i,
    input  wire fspg_pkg::fspg_load_req_t  load_i,
    input  wire logic                      vectors_in_boot_i,
    // Lock programming
    input  wire logic                      app_lock_set_i,
    input  wire fspg_pkg::fspg_pair_t      app_lock_val_i,
    input  wire logic                      boot_lock_set_i,
    input  wire fspg_pkg::fspg_pair_t      boot_lock_val_i,
    input  wire logic                      chip_erase_i,
    // Flash array side
    input  wire logic                      flash_done_i,
    output logic                           flash_start_o,
    output fspg_pkg::fspg_op_t             flash_op_o,
    output logic [fspg_pkg::ADDR_W-1:0]    flash_addr_o,
    output logic                           load_grant_o,
    // Status to the core
    output logic                           program_store_enable_o,
    output logic                           concurrent_region_busy_o,
    output logic                           cpu_halt_o,
    output logic                           irq_suppress_o,
    output fspg_pkg::fspg_pair_t           app_lock_pair_o,
    output fspg_pkg::fspg_pair_t           boot_lock_pair_o
);
    import fspg_pkg::*;

    fspg_state_t state;
    fspg_state_t next_state;
    logic        app_no_store;
    logic        app_no_cross;
    logic        boot_no_store;
    logic        boot_no_cross;
    logic        store_ok;
    logic        prog_start;
    logic        tgt_conc;

    function automatic logic in_boot(input logic [ADDR_W-1:0] a);
        in_boot = (a >= BOOT_START);
    endfunction

    function automatic logic in_conc(input logic [ADDR_W-1:0] a);
        in_conc = (a < HALT_START); // [R3]
    endfunction

    // Two independent pairs, set by software or a programmer, erased only together.
    fspg_lock_pair u_app_lock ( // [R11]
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .set_i        (app_lock_set_i),
        .set_val_i    (app_lock_val_i),
        .chip_erase_i (chip_erase_i),
        .pair_o       (app_lock_pair_o),
        .no_store_o   (app_no_store),
        .no_cross_o   (app_no_cross)
    );

    fspg_lock_pair u_boot_lock ( // [R11]
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .set_i        (boot_lock_set_i),
        .set_val_i    (boot_lock_val_i),
        .chip_erase_i (chip_erase_i),
        .pair_o       (boot_lock_pair_o),
        .no_store_o   (boot_no_store),
        .no_cross_o   (boot_no_cross)
    );

    // A boot start below the boundary would break the halt guarantee.
    initial begin
        if (BOOT_START < HALT_START) begin // [R8]
            $error("boot section must lie within the halting region");
        end
    end

    // Only boot code may store, to any page, and general lock modes are not consulted.
    always_comb begin
        store_ok = store_i.valid && in_boot(store_i.pc) && (state == FSPG_IDLE); // [R1] [R2] [R13]
        if (in_boot(store_i.target)) begin
            store_ok = store_ok && !boot_no_store; // [R18]
        end else begin
            store_ok = store_ok && !app_no_store; // [R15]
        end
    end

    assign tgt_conc   = in_conc(store_i.target);
    assign prog_start = store_ok &&
                        (store_i.op == FSPG_OP_ERASE || store_i.op == FSPG_OP_WRITE);

    // The target region, not the fetch region, decides whether the core halts.
    always_comb begin
        next_state = state;
        unique case (state)
            FSPG_IDLE: begin
                if (prog_start) begin
                    next_state = tgt_conc ? FSPG_CONC : FSPG_HALT; // [R4] [R5] [R6] [R8]
                end
            end
            FSPG_CONC, FSPG_HALT: begin
                if (flash_done_i) begin
                    next_state = FSPG_IDLE;
                end
            end
            default: next_state = FSPG_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= FSPG_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Refused stores never reach the flash and leave no trace.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flash_start_o <= 1'b0;
            flash_op_o    <= FSPG_OP_LOAD;
            flash_addr_o  <= '0;
        end else begin
            flash_start_o <= store_ok && (store_i.op != FSPG_OP_REENABLE); // [R23]
            if (store_ok) begin
                flash_op_o   <= store_i.op;
                flash_addr_o <= store_i.target;
            end
        end
    end

    // Start wins over a clear in the same cycle so a new blocking is never lost.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            concurrent_region_busy_o <= 1'b0;
        end else if (prog_start && tgt_conc) begin
            concurrent_region_busy_o <= 1'b1; // [R21] [R9]
        end else if (store_ok &&
                     (store_i.op == FSPG_OP_REENABLE || store_i.op == FSPG_OP_LOAD)) begin
            concurrent_region_busy_o <= 1'b0; // [R21] [R10]
        end
    end

    assign program_store_enable_o = (state != FSPG_IDLE);
    assign cpu_halt_o = (state == FSPG_HALT); // [R5]

    // Loads into a blocked region are refused too; software should never try.
    always_comb begin
        load_grant_o = load_i.valid && !cpu_halt_o;
        if (concurrent_region_busy_o && in_conc(load_i.target)) begin
            load_grant_o = 1'b0; // [R7] [R9]
        end
        if (in_boot(load_i.pc) && !in_boot(load_i.target) && app_no_cross) begin
            load_grant_o = 1'b0; // [R16] [R23]
        end
        if (!in_boot(load_i.pc) && in_boot(load_i.target) && boot_no_cross) begin
            load_grant_o = 1'b0; // [R19] [R23]
        end
    end

    // The fetch address is the store port's program counter.
    always_comb begin
        irq_suppress_o = 1'b0;
        if (vectors_in_boot_i && app_no_cross && !in_boot(store_i.pc)) begin
            irq_suppress_o = 1'b1; // [R17]
        end
        if (!vectors_in_boot_i && boot_no_cross && in_boot(store_i.pc)) begin
            irq_suppress_o = 1'b1; // [R20]
        end
    end
endmodule

// *** design/fspg_pkg.sv ***
// Constants and carrier types for the flash self-program guard.
// How it works
// [R1] Programming starts only from boot section code.
// [R2] Boot code may target any flash page.
// [R3] Fixed region boundary, independent of boot size.
// [R4] CPU runs while concurrent region programs.
// [R5] CPU halts while halting region programs.
// [R6] Target address region decides the halt.
// [R7] Software never reads concurrent region while busy.
// [R8] Boot section lies inside halting region.
// [R9] Busy flag high while concurrent region blocked.
// [R10] Software clears busy before reading concurrent region.
// [R11] Two independent lock pairs: application and boot.
// [R12] Lock bits only program; chip erase restores.
// [R13] General lock modes do not restrict self-programming.
// [R14] Bit one is unprogrammed; both ones free.
// [R15] App pair modes 2,3 refuse application stores.
// [R16] App pair modes 3,4 refuse boot loads.
// [R17] App pair modes 3,4 suppress interrupts in application.
// [R18] Boot pair modes 2,3 refuse boot stores.
// [R19] Boot pair modes 3,4 refuse application loads.
// [R20] Boot pair modes 3,4 suppress interrupts in boot.
// [R21] Busy sets on start; reenable or page load clears.
// [R22] Boundary and boot size are parameters.
// [R23] Refused requests drop silently.
package fspg_pkg;

    localparam int ADDR_W = 14;

    // Word address of the first halting-region word; the split is fixed.
    localparam logic [ADDR_W-1:0] HALT_START_DEF = 14'h3000;
    // Word address of the first boot-section word, chosen by the size fuses.
    localparam logic [ADDR_W-1:0] BOOT_START_DEF = 14'h3800;

    localparam logic UNPROG = 1'b1;
    localparam logic PROG   = 1'b0;

    // Store operation kinds requested by the core.
    typedef enum logic [1:0] {
        FSPG_OP_LOAD     = 2'b00,
        FSPG_OP_ERASE    = 2'b01,
        FSPG_OP_WRITE    = 2'b10,
        FSPG_OP_REENABLE = 2'b11
    } fspg_op_t;

    // One lock pair: high then low bit.
    typedef struct packed {
        logic high;
        logic low;
    } fspg_pair_t;

    // Store request from the core.
    typedef struct packed {
        logic              valid;
        fspg_op_t          op;
        logic [ADDR_W-1:0] pc;
        logic [ADDR_W-1:0] target;
    } fspg_store_req_t;

    // Load request from the core.
    typedef struct packed {
        logic              valid;
        logic [ADDR_W-1:0] pc;
        logic [ADDR_W-1:0] target;
    } fspg_load_req_t;

    typedef enum logic [1:0] {
        FSPG_IDLE   = 2'b00,
        FSPG_CONC   = 2'b01,
        FSPG_HALT   = 2'b10
    } fspg_state_t;

endpackage

// *** design/fspg_lock_pair.sv ***
// One lock pair register that set only moves toward programmed; reset and chip erase restore it.
`timescale 1ns/10ps
module fspg_lock_pair (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Programming requests
    input  wire logic              set_i,
    input  wire fspg_pkg::fspg_pair_t set_val_i,
    input  wire logic              chip_erase_i,
    // Current pair and decoded modes
    output fspg_pkg::fspg_pair_t   pair_o,
    output logic                   no_store_o,
    output logic                   no_cross_o
);
    import fspg_pkg::*;

    // Reset shows the erased state; real silicon would hold it in nonvolatile cells.
    always_ff @(posedge clk_i) begin
        if (rst_i || chip_erase_i) begin
            pair_o <= '{high: UNPROG, low: UNPROG}; // [R12]
        end else if (set_i) begin
            pair_o <= pair_o & set_val_i; // [R12]
        end
    end

    // Modes 2 and 3 share a programmed low bit, modes 3 and 4 a programmed high bit.
    assign no_store_o = (pair_o.low == PROG);  // [R14]
    assign no_cross_o = (pair_o.high == PROG); // [R14]
endmodule

// *** bench/fspg_guard_properties.sv ***
// Assertion checker for the flash self-program guard.
`timescale 1ns/10ps
module fspg_guard_chk #(
    parameter logic [fspg_pkg::ADDR_W-1:0] HALT_START = fspg_pkg::HALT_START_DEF,
    parameter logic [fspg_pkg::ADDR_W-1:0] BOOT_START = fspg_pkg::BOOT_START_DEF
) (
    // Clock and reset
    input wire logic                      clk_i,
    input wire logic                      rst_i,
    // Requests and controls seen by the guard
    input wire logic                      chip_erase_i,
    input wire logic                      vectors_in_boot_i,
    input wire logic                      flash_done_i,
    input wire fspg_pkg::fspg_store_req_t store_i,
    input wire fspg_pkg::fspg_load_req_t  load_i,
    // Guard outputs
    input wire logic                      flash_start_o,
    input wire logic                      program_store_enable_o,
    input wire logic                      concurrent_region_busy_o,
    input wire logic                      cpu_halt_o,
    input wire logic                      irq_suppress_o,
    input wire logic                      load_grant_o,
    input wire fspg_pkg::fspg_pair_t      app_lock_pair_o,
    input wire fspg_pkg::fspg_pair_t      boot_lock_pair_o
);
    import fspg_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire sb = store_i.pc >= BOOT_START;
    wire lb = load_i.pc >= BOOT_START;
    wire tb = load_i.target >= BOOT_START;
    wire ok = store_i.target >= BOOT_START ? boot_lock_pair_o.low : app_lock_pair_o.low;
    wire acc = store_i.valid && sb && ok && !program_store_enable_o;
    wire pg = acc && store_i.op inside {FSPG_OP_ERASE, FSPG_OP_WRITE};
    wire clr = acc && store_i.op inside {FSPG_OP_LOAD, FSPG_OP_REENABLE};
    property p_start; acc && store_i.op != FSPG_OP_REENABLE |=> flash_start_o; endproperty
    a_start: assert property (p_start) else $error("store not started");
    property p_app; store_i.valid && !sb |=> !flash_start_o; endproperty
    a_app: assert property (p_app) else $error("application store started");
    property p_lock; store_i.valid && !ok |=> !flash_start_o; endproperty
    a_lock: assert property (p_lock) else $error("locked store started");
    property p_halt; pg && store_i.target >= HALT_START |=> cpu_halt_o; endproperty
    a_halt: assert property (p_halt) else $error("no halt");
    property p_conc; pg && store_i.target < HALT_START |=> concurrent_region_busy_o && !cpu_halt_o;
    endproperty
    a_conc: assert property (p_conc) else $error("busy or halt wrong");
    property p_hold; cpu_halt_o && !flash_done_i |=> cpu_halt_o; endproperty
    a_hold: assert property (p_hold) else $error("halt dropped early");
    property p_irq; irq_suppress_o == (!app_lock_pair_o.high && vectors_in_boot_i && !sb
        || !boot_lock_pair_o.high && !vectors_in_boot_i && sb); endproperty
    a_irq: assert property (p_irq) else $error("interrupt suppression wrong");
    property p_load; load_i.valid && (cpu_halt_o || lb && !tb && !app_lock_pair_o.high
        || !lb && tb && !boot_lock_pair_o.high
        || concurrent_region_busy_o && load_i.target < HALT_START) |-> !load_grant_o; endproperty
    a_load: assert property (p_load) else $error("load granted");
    property p_mono; $rose(app_lock_pair_o.high) || $rose(app_lock_pair_o.low)
        || $rose(boot_lock_pair_o.high) || $rose(boot_lock_pair_o.low)
        |-> $past(chip_erase_i); endproperty
    a_mono: assert property (p_mono) else $error("lock bit unprogrammed");
    property p_clr; clr |=> !concurrent_region_busy_o; endproperty
    a_clr: assert property (p_clr) else $error("busy flag not cleared");
endmodule
bind fspg_guard fspg_guard_chk #(.HALT_START(HALT_START), .BOOT_START(BOOT_START)) i_chk (.*);

// *** bench/fspg_core_model.sv ***
// Behavioural core and flash array that face the guard.
`timescale 1ns/10ps
module fspg_core_model import fspg_pkg::*; (
    input  wire logic      clk_i,
    input  wire logic      flash_start_i,
    input  wire fspg_op_t  flash_op_i,
    input  wire logic      load_grant_i,
    output fspg_store_req_t store_o,
    output fspg_load_req_t  load_o,
    output logic            flash_done_o
);
    int lat = 8;
    int cnt = 0;
    initial begin
        store_o = '0;
        load_o = '0;
        flash_done_o = 1'b0;
    end
    // Slow enough that a second store lands while the first is still running.
    always @(posedge clk_i) begin
        flash_done_o <= cnt == 1;
        if (flash_start_i && flash_op_i inside {FSPG_OP_ERASE, FSPG_OP_WRITE}) cnt <= lat;
        else if (cnt > 0) cnt <= cnt - 1;
    end
    task automatic store(input fspg_op_t op, input logic [13:0] pc, tgt);
        @(posedge clk_i) #1 store_o = '{1'b1, op, pc, tgt};
        @(posedge clk_i) #1 store_o = '{1'b0, op, pc, ~tgt};
    endtask
    // The grant is taken at the edge that samples the request, before the state moves on.
    task automatic load(input logic [13:0] pc, tgt, output logic g);
        @(posedge clk_i) #1 load_o = '{1'b1, pc, tgt};
        @(posedge clk_i) g = load_grant_i;
        #1 load_o = '{1'b0, pc, ~tgt};
    endtask
endmodule

// *** bench/fspg_guard_tb.sv ***
// Self-checking bench for the flash self-program guard.
`timescale 1ns/10ps
module fspg_guard_tb;
    import fspg_pkg::*;
    logic clk_i = 0, rst_i = 1, vib = 0, aset = 0, bset = 0, ce = 0, g;
    logic done, start, grant, pse, busy, halt, irq;
    logic [13:0] fa;
    fspg_pair_t aval = 2'b11, bval = 2'b11, ap, bp;
    fspg_store_req_t st;
    fspg_load_req_t ld;
    fspg_op_t fop;
    int err_total = 0, checks_done = 0;
    always #25 clk_i = ~clk_i;
    fspg_core_model i_core (.clk_i, .flash_start_i(start), .flash_op_i(fop),
        .load_grant_i(grant), .store_o(st), .load_o(ld), .flash_done_o(done));
    fspg_guard i_dut (.clk_i, .rst_i, .store_i(st), .load_i(ld), .vectors_in_boot_i(vib),
        .app_lock_set_i(aset), .app_lock_val_i(aval), .boot_lock_set_i(bset),
        .boot_lock_val_i(bval), .chip_erase_i(ce), .flash_done_i(done), .flash_start_o(start),
        .flash_op_o(fop), .flash_addr_o(fa), .load_grant_o(grant), .program_store_enable_o(pse),
        .concurrent_region_busy_o(busy), .cpu_halt_o(halt), .irq_suppress_o(irq),
        .app_lock_pair_o(ap), .boot_lock_pair_o(bp));
    task automatic chk(input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wait_idle;
        for (int i = 0; i < 40 && pse; i++) @(posedge clk_i) #1;
        chk({pse, halt}, 0);
    endtask
    task automatic t_prog(input fspg_op_t op, clr, input logic [13:0] tgt, input logic hlt);
        i_core.store(op, 14'h3900, tgt);
        chk({start, fop, fa}, {1'b1, op, tgt});
        chk({halt, busy, pse}, {hlt, !hlt, 1'b1});
        // Deliberate misuse: reading the page under programming must be refused.
        i_core.load(14'h3900, tgt, g);
        chk(g, 0);
        i_core.load(14'h3900, 14'h3100, g);
        chk(g, !hlt);
        i_core.store(FSPG_OP_ERASE, 14'h3900, 14'h0400);
        chk(start, 0);
        wait_idle;
        i_core.store(clr, 14'h3900, tgt);
        chk({halt, busy}, 0);
    endtask
    task automatic t_locks;
        fspg_pair_t md[4] = '{2'b11, 2'b10, 2'b00, 2'b01};
        for (int p = 0; p < 2; p++) for (int m = 0; m < 4; m++) begin
            @(posedge clk_i) #1 ce = 1;
            @(posedge clk_i) #1 ce = 0;
            {aval, bval} = p ? {2'b11, md[m]} : {md[m], 2'b11};
            {aset, bset} = 2'b11;
            @(posedge clk_i) #1 {aval, bval} = 4'hf;
            chk(p ? {bp, ap} : {ap, bp}, {md[m], 2'b11});
            @(posedge clk_i) #1 {aset, bset} = 2'b00;
            chk(p ? bp : ap, md[m]);
            i_core.store(FSPG_OP_ERASE, 14'h3900, p ? 14'h3a00 : 14'h3100);
            chk(start, md[m].low);
            wait_idle;
            i_core.load(p ? 14'h0100 : 14'h3900, p ? 14'h3a00 : 14'h3200, g);
            chk(g, md[m].high);
            vib = !p;
            i_core.store_o.pc = p ? 14'h3900 : 14'h0100;
            #1 chk(irq, !md[m].high);
        end
    endtask
    // Reset leaves both pairs erased and the guard idle; application code may never store.
    task automatic t_reset_app;
        chk({ap, bp, busy, pse, halt, start}, 8'hf0);
        i_core.store(FSPG_OP_ERASE, 14'h0100, 14'h0200);
        chk({start, pse}, 0);
    endtask
    initial begin
        #200us err_total++;
        summarize;
    end
    initial begin
        repeat (5) @(posedge clk_i);
        #1 rst_i = 0;
        t_reset_app;
        t_prog(FSPG_OP_ERASE, FSPG_OP_LOAD, 14'h0100, 1'b0);
        t_prog(FSPG_OP_ERASE, FSPG_OP_REENABLE, 14'h3000, 1'b1);
        t_prog(FSPG_OP_WRITE, FSPG_OP_REENABLE, 14'h3100, 1'b1);
        t_prog(FSPG_OP_WRITE, FSPG_OP_REENABLE, 14'h3a00, 1'b1);
        t_prog(FSPG_OP_WRITE, FSPG_OP_REENABLE, 14'h2ffe, 1'b0);
        t_locks;
        summarize;
    end
endmodule
